/* File: hdl/scp_host.sv */
// Host end: serial master driving frames from a user request
`timescale 1ns/1ps
`default_nettype none
module scp_host
	import scp_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic req_i,
	input wire logic read_i,
	input wire logic [6:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic busy_o,
	output logic done_o,
	output logic [15:0] rdata_o,
	scp_if.host link
);
	// ==========================================================
	// Read-back synchroniser
	logic [2:0] din_meta;
	logic [2:0] din_sync;
	logic [2:0] din_raw;
	logic din_bit;

	// Mode bit and both data pins cross before any logic reads them
	assign din_raw = {link.four_pin_select, link.serial_data_out_pin, link.sdio_d_o};
	assign din_bit = din_sync[2] ? din_sync[1] : din_sync[0];

	// Two-stage sampling of the device pins
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			din_meta <= 3'h0;
			din_sync <= 3'h0;
		end else begin
			din_meta <= din_raw;
			din_sync <= din_meta;
		end
	end

	// ==========================================================
	// Frame sequencer
	scp_state_t state;
	scp_state_t next_state;
	logic [7:0] tick;
	logic [7:0] next_tick;
	logic [7:0] half;
	logic [7:0] next_half;
	logic [4:0] bits;
	logic [4:0] next_bits;
	logic [23:0] shreg;
	logic [23:0] next_shreg;
	logic [15:0] rx;
	logic [15:0] next_rx;
	logic rd;
	logic next_rd;
	logic done;
	logic next_done;

	// Next state of the master
	always_comb begin
		next_state = state;
		next_tick = tick;
		next_half = half;
		next_bits = bits;
		next_shreg = shreg;
		next_rx = rx;
		next_rd = rd;
		next_done = 1'b0;
		if (tick != 8'h00) begin
			next_tick = tick - 8'h01;
		end
		case (state)
			SCP_IDLE: begin
				if (req_i) begin
					next_shreg = {read_i, addr_i, wdata_i};
					next_rd = read_i;
					next_bits = 5'h00;
					next_half = (addr_i == SCP_TEMP_RESULT_ADDR && read_i) ? SCP_TEMP_HALF_CNT : SCP_HALF_CNT;
					next_tick = next_half;
					next_state = SCP_SELECT;
				end
			end
			SCP_SELECT: begin
				if (tick == 8'h00) begin
					next_tick = half;
					next_state = SCP_LOW;
				end
			end
			SCP_LOW: begin
				if (tick == 8'h00) begin
					next_tick = half;
					next_state = SCP_HIGH;
				end
			end
			SCP_HIGH: begin
				if (tick == 8'h00) begin
					if (bits >= SCP_INSTR_LAST + 5'h01) begin
						next_rx = {rx[14:0], din_bit};
					end
					next_shreg = {shreg[22:0], 1'b0};
					next_bits = bits + 5'h01;
					next_tick = half;
					next_state = (bits == SCP_LAST_BIT) ? SCP_DONE : SCP_LOW;
				end
			end
			SCP_DONE: begin
				if (tick == 8'h00) begin
					next_done = 1'b1;
					next_state = SCP_IDLE;
				end
			end
			default: begin
				next_state = SCP_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= SCP_IDLE;
			tick <= 8'h00;
			half <= SCP_HALF_CNT;
			bits <= 5'h00;
			shreg <= 24'h000000;
			rx <= 16'h0000;
			rd <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			tick <= next_tick;
			half <= next_half;
			bits <= next_bits;
			shreg <= next_shreg;
			rx <= next_rx;
			rd <= next_rd;
			done <= next_done;
		end
	end

	// Pin drive; data pin released during a read data phase
	assign link.sclk = (state == SCP_HIGH);
	assign link.serial_frame_select_n = (state == SCP_IDLE);
	assign link.sdio_m_o = shreg[23];
	assign link.sdio_m_oe_n = (state == SCP_IDLE) || (rd && bits > SCP_INSTR_LAST);
	assign busy_o = (state != SCP_IDLE);
	assign done_o = done;
	assign rdata_o = rx;
endmodule
`default_nettype wire

/* File: pkg/scp_pkg.sv */
// Constants and types shared by both ends of the serial configuration port
package scp_pkg;
	// ==========================================================
	// Frame layout
	localparam int SCP_INSTR_BITS = 8;
	localparam int SCP_DATA_BITS = 16;
	localparam int SCP_FRAME_BITS = 24;
	localparam int SCP_DIR_POS = 7;
	localparam int SCP_ADDR_W = 7;
	localparam logic [4:0] SCP_LAST_BIT = 5'h17;
	localparam logic [4:0] SCP_INSTR_LAST = 5'h07;
	// ==========================================================
	// Register map
	localparam logic [6:0] SCP_SECOND_CONFIG_ADDR = 7'h02;
	localparam logic [6:0] SCP_TEMP_RESULT_ADDR = 7'h06;
	localparam int SCP_FOUR_PIN_POS = 7;
	localparam logic [15:0] SCP_REG_RESET = 16'h0000;
	// ==========================================================
	// Timing
	localparam int SCP_REF_CLK_NS = 100;
	localparam int SCP_SCLK_MIN_NS = 100;
	localparam int SCP_TEMP_SCLK_MIN_US = 1;
	localparam int SCP_HALF_CYCLES = (SCP_SCLK_MIN_NS + 2 * SCP_REF_CLK_NS - 1) / (2 * SCP_REF_CLK_NS);
	localparam int SCP_TEMP_HALF_CYCLES = (SCP_TEMP_SCLK_MIN_US * 1000 + 2 * SCP_REF_CLK_NS - 1)
		/ (2 * SCP_REF_CLK_NS);
	localparam logic [7:0] SCP_HALF_CNT = 8'(SCP_HALF_CYCLES);
	localparam logic [7:0] SCP_TEMP_HALF_CNT = 8'(SCP_TEMP_HALF_CYCLES);
	// ==========================================================
	// Master states, Gray from IDLE to DONE; DONE back to IDLE flips two bits
	typedef enum logic [2:0] {
		SCP_IDLE = 3'b000,
		SCP_SELECT = 3'b001,
		SCP_LOW = 3'b011,
		SCP_HIGH = 3'b010,
		SCP_DONE = 3'b110
	} scp_state_t;
endpackage

/* File: pkg/scp_if.sv */
// Pin-level interface between serial master and configuration port
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
	logic sclk;
	logic serial_frame_select_n;
	logic sdio_m_o;
	logic sdio_m_oe_n;
	logic sdio_d_o;
	logic sdio_d_oe_n;
	logic serial_data_out_pin;
	logic serial_data_out_oe_n;
	logic four_pin_select;
	modport device (
		input sclk, serial_frame_select_n, sdio_m_o, sdio_m_oe_n,
		output sdio_d_o, sdio_d_oe_n, serial_data_out_pin, serial_data_out_oe_n, four_pin_select
	);
	modport host (
		output sclk, serial_frame_select_n, sdio_m_o, sdio_m_oe_n,
		input sdio_d_o, sdio_d_oe_n, serial_data_out_pin, serial_data_out_oe_n, four_pin_select
	);
endinterface
`default_nettype wire

/* File: hdl/scp_device.sv */
// Device end: shift engine on the serial clock plus 128 x 16 register file
`timescale 1ns/1ps
`default_nettype none
module scp_device
	import scp_pkg::*;
(
	scp_if.device link,
	input wire logic reset_n_i,
	input wire logic [15:0] temperature_i,
	output logic [15:0] second_config_o
);
	// ==========================================================
	// Rising-edge capture state
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic [7:0] instr;
	logic [7:0] next_instr;
	logic [15:0] wdata;
	logic [15:0] next_wdata;
	logic [15:0] regs [0:127];
	logic sdi;
	logic frame_rst_n;
	logic four_pin;
	logic is_read;

	assign frame_rst_n = reset_n_i & ~link.serial_frame_select_n;
	assign four_pin = regs[SCP_SECOND_CONFIG_ADDR][SCP_FOUR_PIN_POS];
	assign sdi = link.sdio_m_o;
	assign is_read = instr[SCP_DIR_POS];
	assign second_config_o = regs[SCP_SECOND_CONFIG_ADDR];
	assign link.four_pin_select = four_pin;

	// Next counter, instruction and write shift values
	always_comb begin
		next_bit_cnt = bit_cnt;
		next_instr = instr;
		next_wdata = wdata;
		if (bit_cnt != SCP_LAST_BIT + 5'h01) begin
			next_bit_cnt = bit_cnt + 5'h01;
		end
		if (bit_cnt <= SCP_INSTR_LAST) begin
			next_instr = {instr[6:0], sdi};
		end else if (bit_cnt <= SCP_LAST_BIT) begin
			next_wdata = {wdata[14:0], sdi};
		end
	end

	// Frame state cleared whenever select is high
	always_ff @(posedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt <= 5'h00;
			instr <= 8'h00;
			wdata <= 16'h0000;
		end else begin
			bit_cnt <= next_bit_cnt;
			instr <= next_instr;
			wdata <= next_wdata;
		end
	end

	// Register file written only on the last bit of a write frame
	genvar gi;
	generate
		for (gi = 0; gi < 128; gi++) begin : g_reg
			logic [15:0] next_val;
			always_comb begin
				next_val = regs[gi];
				if (bit_cnt == SCP_LAST_BIT && !is_read && instr[6:0] == 7'(gi)) begin
					next_val = {wdata[14:0], sdi};
				end
			end
			always_ff @(posedge link.sclk or negedge reset_n_i) begin
				if (!reset_n_i) begin
					regs[gi] <= SCP_REG_RESET;
				end else if (!link.serial_frame_select_n) begin
					regs[gi] <= next_val;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Falling-edge launch state
	logic [15:0] rdata;
	logic [15:0] next_rdata;
	logic [15:0] src;
	logic drive;
	logic next_drive;
	logic out_bit;
	logic next_out_bit;

	assign src = (instr[6:0] == SCP_TEMP_RESULT_ADDR) ? temperature_i : regs[instr[6:0]];

	// Load on the fall after the instruction, then shift out
	always_comb begin
		next_rdata = rdata;
		next_drive = drive;
		next_out_bit = out_bit;
		if (is_read && bit_cnt == SCP_INSTR_LAST + 5'h01) begin
			next_rdata = {src[14:0], 1'b0};
			next_out_bit = src[15];
			next_drive = 1'b1;
		end else if (drive) begin
			next_rdata = {rdata[14:0], 1'b0};
			next_out_bit = (bit_cnt > SCP_LAST_BIT) ? 1'b0 : rdata[15];
		end
	end

	always_ff @(negedge link.sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rdata <= 16'h0000;
			drive <= 1'b0;
			out_bit <= 1'b0;
		end else begin
			rdata <= next_rdata;
			drive <= next_drive;
			out_bit <= next_out_bit;
		end
	end

	// Pin steering by mode
	assign link.sdio_d_o = out_bit;
	assign link.sdio_d_oe_n = ~(drive & ~four_pin);
	assign link.serial_data_out_pin = out_bit;
	assign link.serial_data_out_oe_n = ~(drive & four_pin);
endmodule
`default_nettype wire

/* File: verification/scp_monitor.sv */
// Link checker for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module scp_monitor (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic sclk,
	input wire logic serial_frame_select_n,
	input wire logic sdio_m_o,
	input wire logic sdio_m_oe_n,
	input wire logic sdio_d_o,
	input wire logic sdio_d_oe_n,
	input wire logic serial_data_out_pin,
	input wire logic serial_data_out_oe_n,
	input wire logic four_pin_select
);
	logic sclk_q;
	logic [4:0] rises;
	logic [4:0] next_rises;
	// ======
	// Rising clock edges seen in the current frame
	always_comb begin
		next_rises = serial_frame_select_n ? 5'h00 : rises + 5'(sclk & ~sclk_q);
	end
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sclk_q <= 1'b0;
			rises <= 5'h00;
		end else begin
			sclk_q <= sclk;
			rises <= next_rises;
		end
	end
	// ======
	// Properties
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_frame_end;
		$rose(serial_frame_select_n);
	endsequence
	a_frame_bits: assert property (s_frame_end |-> rises == 5'h18)
		else $error("frame length wrong");
	a_tail_low: assert property (rises == 5'h18 && !sclk |-> (sdio_d_oe_n || !sdio_d_o)
		&& (serial_data_out_oe_n || !serial_data_out_pin)) else $error("tail not low");
	a_idle_released: assert property (serial_frame_select_n && $past(serial_frame_select_n)
		|-> sdio_d_oe_n && serial_data_out_oe_n) else $error("pins driven while idle");
	a_three_pin_out: assert property (!four_pin_select |-> serial_data_out_oe_n)
		else $error("output pin driven in three pin mode");
	a_four_pin_in: assert property (four_pin_select |-> sdio_d_oe_n)
		else $error("data pin driven in four pin mode");
	a_launch_fall: assert property (!sdio_d_oe_n && $stable(sdio_d_oe_n) && !$stable(sdio_d_o)
		|-> $fell(sclk)) else $error("bit launched off falling edge");
	a_host_steady: assert property (!serial_frame_select_n && sclk |-> $stable(sdio_m_o))
		else $error("host data moved in high phase");
	a_clock_framed: assert property ($rose(sclk) |-> !serial_frame_select_n)
		else $error("clock outside frame");
	a_instr_input: assert property (rises < 5'h08 |-> sdio_d_oe_n)
		else $error("device drove during instruction");
	a_no_contention: assert property (!sdio_m_oe_n |-> sdio_d_oe_n)
		else $error("both ends drive the data pin");
	a_drive_held: assert property (!serial_frame_select_n && !$past(sdio_d_oe_n && serial_data_out_oe_n)
		|-> !(sdio_d_oe_n && serial_data_out_oe_n)) else $error("read drive dropped before deselect");
	a_launch_fall_out: assert property (!serial_data_out_oe_n && $stable(serial_data_out_oe_n)
		&& !$stable(serial_data_out_pin) |-> $fell(sclk)) else $error("output pin bit launched off falling edge");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Bench joining host and device ends of the configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_i = 1'b0;
	logic reset_n_i;
	time t0;
	logic req_i = 1'b0;
	logic read_i = 1'b0;
	logic [6:0] addr_i = 7'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic [15:0] temperature_i = 16'h1234;
	logic busy_o;
	logic done_o;
	logic [15:0] rdata_o;
	logic [15:0] second_config_o;
	logic [15:0] cfg2;
	int err_total = 0;
	int total_checks = 0;
	scp_if link();
	scp_if link2();
	scp_host u_scp_host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .read_i(read_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .link(link));
	scp_device u_scp_device (.link(link), .reset_n_i(reset_n_i), .temperature_i(temperature_i),
		.second_config_o(second_config_o));
	scp_device u_scp_device_2 (.link(link2), .reset_n_i(reset_n_i), .temperature_i(16'h0000),
		.second_config_o(cfg2));
	scp_monitor u_scp_monitor (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .sclk(link.sclk),
		.serial_frame_select_n(link.serial_frame_select_n), .sdio_m_o(link.sdio_m_o),
		.sdio_m_oe_n(link.sdio_m_oe_n), .sdio_d_o(link.sdio_d_o),
		.sdio_d_oe_n(link.sdio_d_oe_n), .serial_data_out_pin(link.serial_data_out_pin),
		.serial_data_out_oe_n(link.serial_data_out_oe_n), .four_pin_select(link.four_pin_select));
	// Reference clock
	always #50 ref_clk_i = ~ref_clk_i;
	// ======
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d);
		int n;
		@(posedge ref_clk_i);
		req_i <= 1'b1;
		read_i <= rd;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		req_i <= 1'b0;
		for (n = 0; n < 2000 && done_o !== 1'b1; n++) @(negedge ref_clk_i);
		if (n == 2000) begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic wr_rd(input logic [6:0] a, input logic [15:0] d);
		xfer(1'b0, a, d);
		xfer(1'b1, a, 16'h0000);
		chk(rdata_o, d);
	endtask
	// Bench-made 80 ns link clock, still outside frames
	task automatic frame2(input int bits, input logic [23:0] v);
		link2.serial_frame_select_n = 1'b0;
		link2.sdio_m_oe_n = 1'b0;
		for (int i = 23; i > 23 - bits; i--) begin
			link2.sdio_m_o = v[i];
			#40 link2.sclk = 1'b1;
			#40 link2.sclk = 1'b0;
		end
		#40 link2.serial_frame_select_n = 1'b1;
		link2.sdio_m_oe_n = 1'b1;
		link2.sdio_m_o = ~link2.sdio_m_o;
		#80; // Deselect gap so the next frame starts clean
	endtask
	// ======
	// Main sequence
	initial begin
		reset_n_i <= 1'b0; // Real falling edge so every async reset fires
		link2.sclk = 1'b0;
		link2.serial_frame_select_n = 1'b1;
		link2.sdio_m_o = 1'b0;
		link2.sdio_m_oe_n = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		xfer(1'b1, 7'h02, 16'h0000);
		chk(rdata_o, 16'h0000);
		wr_rd(7'h05, 16'hA55A);
		wr_rd(7'h7F, 16'h8001);
		t0 = $time;
		xfer(1'b1, 7'h06, 16'h0000);
		chk(rdata_o, 16'h1234);
		chk({15'h0000, ($time - t0) >= 64'h5DC0}, 16'h0001);
		xfer(1'b0, 7'h02, 16'h0080);
		chk(second_config_o, 16'h0080);
		chk({15'h0000, link.four_pin_select}, 16'h0001);
		xfer(1'b1, 7'h05, 16'h0000);
		chk(rdata_o, 16'hA55A);
		wr_rd(7'h00, 16'h5AA5);
		frame2(20, 24'h02FF80);
		chk(cfg2, 16'h0000);
		frame2(24, 24'h02FF80);
		chk(cfg2, 16'hFF80);
		// Mid-run reset: registers and mode return to defaults
		@(posedge ref_clk_i);
		reset_n_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		chk(second_config_o, 16'h0000);
		chk(cfg2, 16'h0000);
		reset_n_i <= 1'b1;
		xfer(1'b1, 7'h02, 16'h0000);
		chk(rdata_o, 16'h0000);
		chk({15'h0000, link.four_pin_select}, 16'h0000);
		wr_rd(7'h11, 16'h3CC3);
		wrap_up();
	end
endmodule
`default_nettype wire
